// File: verilog/uhpc_pkg.sv
package uhpc_pkg;
   localparam int NPORTS = 4;
   localparam int CLK_HZ = 20_000_000;
   localparam int MS_CYCLES = CLK_HZ / 1000;
   localparam logic [3:0] OC_WIN_DEFAULT_MS = 4'h8;
   localparam int OC_CNT_W = 19;
   localparam int PRESENT_CYCLES = 2;

   // APB register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_PORT_CMD = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_PORT_STAT = 8'h10;
   localparam logic [7:0] ADDR_CHANGE = 8'h14;

   // Port command codes, written to PORT_CMD[2:0] with port in [5:4]
   localparam logic [2:0] CMD_SET_POWER = 3'h1;
   localparam logic [2:0] CMD_CLR_POWER = 3'h2;
   localparam logic [2:0] CMD_SET_RESET = 3'h3;
   localparam logic [2:0] CMD_CLR_ENABLE = 3'h4;
   localparam logic [2:0] CMD_SET_SUSPEND = 3'h5;
   localparam logic [2:0] CMD_CLR_SUSPEND = 3'h6;

   // CFG field positions
   localparam int CFG_PORTS_LSB = 0;
   localparam int CFG_REMOV_LSB = 4;
   localparam int CFG_PWR_POL = 8;
   localparam int CFG_OC_POL = 9;
   localparam int CFG_GANGED = 10;
   localparam int CFG_OC_EN_LSB = 12;
   localparam int CFG_OC_DIS_LSB = 16;
   localparam int CFG_LED_MAN = 20;
   localparam logic [31:0] CFG_RESET = 32'h0008_880F;

   // CTRL bits
   localparam int CTRL_LOAD_DONE = 0;
   localparam int CTRL_CONFIGURED = 1;
   localparam int CTRL_HUB_SUSP = 2;
   localparam int CTRL_LED_OVR_LSB = 4;

   localparam int PORT_RESET_CYCLES = 10 * MS_CYCLES;

   typedef enum logic [4:0] {
      UP_LOAD = 5'b00001,
      UP_WAIT_VBUS = 5'b00010,
      UP_ATTACHED = 5'b00100,
      UP_CHIRP = 5'b01000,
      UP_RUN = 5'b10000
   } uhpc_up_t;
endpackage

// File: verilog/uhpc_top.sv
`timescale 1ns/100ps
module uhpc_top (
   input wire logic REF_CLK, // 20 MHz clock
   input wire logic NRST, // Synchronous reset, active low
   input wire logic [7:0] PADDR, // APB address
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB enable
   input wire logic PWRITE, // APB direction
   input wire logic [31:0] PWDATA, // APB write data
   output logic [31:0] PRDATA, // APB read data
   output logic PREADY, // APB ready
   output logic PSLVERR, // APB error
   input wire logic CFG_LOAD_DONE, // Serial config load finished, same clock
   input wire logic UPSTREAM_BUS_POWER_SENSE, // Upstream VBUS pin
   input wire logic UP_BUS_RESET, // Upstream bus reset seen, same clock
   input wire logic UP_CHIRP_ANSWER, // Upstream chirp sequence seen, same clock
   output logic UP_PULLUP_EN, // D+ pull-up enable
   output logic UP_CHIRP_TX, // Chirp sent during reset
   output logic UP_HIGH_SPEED, // Hub runs high speed
   output logic UP_WAKE_FWD, // Remote wakeup forwarded upstream
   output logic UP_TX_BLOCK, // Blocks downstream babble/disconnect upstream
   input wire logic [3:0] DN_CONNECT, // Port device present pins
   input wire logic [3:0] DN_HS_DEV, // Port device is high speed
   input wire logic [3:0] DN_NONIDLE, // Port line not idle pins
   input wire logic [3:0] DN_WAKE, // Port remote wakeup pins
   input wire logic EOF2_PAST, // Past EOF2 point, same clock
   input wire logic PKT_BOUNDARY, // Repeater at packet boundary, same clock
   output logic [3:0] DN_SE0_DRIVE, // Drive both data lines low
   output logic [3:0] DN_PORT_RESET, // Port reset signalling
   output logic [3:0] DN_ROUTE_TT, // Route port through translator
   output logic [3:0] DN_ROUTE_RPT, // Route port through repeater
   output logic [3:0] PORT_POWER_ENABLE_N, // Power switch enables, polarity per config
   input wire logic [3:0] PORT_OVERCURRENT_SENSE_N, // Overcurrent pins
   output logic [3:0] LED_GREEN, // Green indicators
   output logic [3:0] LED_AMBER, // Amber indicators
   output logic HUB_CHANGE_EP1 // Status change pending on endpoint 1
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [31:0] cfg;
      logic configured;
      logic hub_susp;
      logic [3:0] led_ovr;
      uhpc_pkg::uhpc_up_t up;
      logic hs;
      logic [3:0] power;
      logic [3:0] enabled;
      logic [3:0] suspended;
      logic [3:0] oc_flag;
      logic [3:0] change;
      logic [3:0] conn_q;
      logic [3:0] resetting;
      logic [3:0] route_tt;
      logic [3:0] route_rpt;
      logic wake_fwd;
      logic [31:0] prdata;
      logic [1:0] vbus_s;
      logic [7:0] oc_s;
      logic [7:0] conn_s;
      logic [7:0] idle_s;
      logic [7:0] wake_s;
      logic [17:0] rst_cnt;
      logic [4*uhpc_pkg::OC_CNT_W-1:0] oc_cnt;
   } uhpc_state_t;

   uhpc_state_t st_reg;
   uhpc_state_t st_next;
   logic [3:0] oc_active;
   logic [3:0] oc_done;
   logic [3:0] usable;
   logic [3:0] ports_cfg;

   assign ports_cfg = st_reg.cfg[uhpc_pkg::CFG_PORTS_LSB +: 4];
   assign usable = ports_cfg;

   ////////////////////////////////////////////////////////////////////////
   // Overcurrent filters, one per port
   genvar gi;
   generate
      for (gi = 0; gi < uhpc_pkg::NPORTS; gi = gi + 1) begin : g_oc
         logic [3:0] win_ms;
         logic [uhpc_pkg::OC_CNT_W-1:0] win_cyc;
         // Sense polarity from config; second sync stage only.
         assign oc_active[gi] = st_reg.oc_s[4 + gi] ^ ~st_reg.cfg[uhpc_pkg::CFG_OC_POL];
         assign win_ms = st_reg.enabled[gi] ? st_reg.cfg[uhpc_pkg::CFG_OC_EN_LSB +: 4]
                                            : st_reg.cfg[uhpc_pkg::CFG_OC_DIS_LSB +: 4];
         assign win_cyc = uhpc_pkg::OC_CNT_W'(win_ms * uhpc_pkg::MS_CYCLES);
         assign oc_done[gi] = oc_active[gi] &&
            (st_reg.oc_cnt[gi*uhpc_pkg::OC_CNT_W +: uhpc_pkg::OC_CNT_W] >= win_cyc);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic apb_wr;
      logic apb_rd;
      logic [1:0] cp;
      logic [2:0] cmd;
      logic [3:0] conn;
      logic [3:0] nonidle;
      logic [3:0] wake;
      logic [3:0] hit;
      apb_wr = 1'b0;
      apb_rd = 1'b0;
      cp = 2'h0;
      cmd = 3'h0;
      conn = 4'h0;
      nonidle = 4'h0;
      wake = 4'h0;
      hit = 4'h0;
      st_next = st_reg;
      apb_wr = PSEL && PENABLE && PWRITE;
      apb_rd = PSEL && !PENABLE && !PWRITE;
      st_next.vbus_s = {st_reg.vbus_s[0], UPSTREAM_BUS_POWER_SENSE};
      st_next.oc_s = {st_reg.oc_s[3:0], PORT_OVERCURRENT_SENSE_N};
      st_next.conn_s = {st_reg.conn_s[3:0], DN_CONNECT};
      st_next.idle_s = {st_reg.idle_s[3:0], DN_NONIDLE};
      st_next.wake_s = {st_reg.wake_s[3:0], DN_WAKE};
      conn = st_reg.conn_s[7:4] & usable;
      nonidle = st_reg.idle_s[7:4];
      wake = st_reg.wake_s[7:4];
      st_next.wake_fwd = 1'b0;

      // Upstream attach and speed
      case (st_reg.up)
         uhpc_pkg::UP_LOAD: begin
            if (CFG_LOAD_DONE) begin
               st_next.up = uhpc_pkg::UP_WAIT_VBUS;
            end
         end
         uhpc_pkg::UP_WAIT_VBUS: begin
            if (st_reg.vbus_s[1]) begin
               st_next.up = uhpc_pkg::UP_ATTACHED;
            end
         end
         uhpc_pkg::UP_ATTACHED, uhpc_pkg::UP_RUN: begin
            if (!st_reg.vbus_s[1]) begin
               st_next.up = uhpc_pkg::UP_WAIT_VBUS;
               st_next.hs = 1'b0;
            end else if (UP_BUS_RESET) begin
               st_next.up = uhpc_pkg::UP_CHIRP;
               st_next.hs = 1'b0;
            end
         end
         uhpc_pkg::UP_CHIRP: begin
            if (UP_CHIRP_ANSWER) begin
               st_next.hs = 1'b1;
            end
            if (!UP_BUS_RESET) begin
               st_next.up = uhpc_pkg::UP_RUN; // Full speed stays if unanswered
            end
         end
         default: begin
            st_next.up = uhpc_pkg::UP_LOAD;
         end
      endcase
      if (st_reg.up == uhpc_pkg::UP_CHIRP || st_reg.up == uhpc_pkg::UP_WAIT_VBUS) begin
         st_next.configured = 1'b0;
         st_next.hub_susp = 1'b0;
      end

      // Per-port state
      for (int i = 0; i < uhpc_pkg::NPORTS; i++) begin
         if (oc_active[i] && !oc_done[i]) begin
            st_next.oc_cnt[i*uhpc_pkg::OC_CNT_W +: uhpc_pkg::OC_CNT_W] =
               st_reg.oc_cnt[i*uhpc_pkg::OC_CNT_W +: uhpc_pkg::OC_CNT_W] + 1'b1;
         end else if (!oc_active[i]) begin
            st_next.oc_cnt[i*uhpc_pkg::OC_CNT_W +: uhpc_pkg::OC_CNT_W] = '0;
         end
         st_next.conn_q[i] = conn[i];
         if (st_reg.power[i] && conn[i] != st_reg.conn_q[i]) begin
            st_next.change[i] = 1'b1;
            if (!conn[i]) begin
               st_next.enabled[i] = 1'b0;
               st_next.suspended[i] = 1'b0;
            end
         end
         if (st_reg.enabled[i] && EOF2_PAST && nonidle[i] && !st_reg.suspended[i]) begin
            st_next.enabled[i] = 1'b0;
            st_next.change[i] = 1'b1;
         end
         if (st_reg.suspended[i] && wake[i]) begin
            st_next.suspended[i] = 1'b0;
            if (st_reg.hub_susp) begin
               st_next.wake_fwd = 1'b1;
            end else begin
               st_next.change[i] = 1'b1;
            end
         end
         if (oc_done[i] && st_reg.power[i]) begin
            st_next.oc_flag[i] = 1'b1;
            st_next.change[i] = 1'b1;
            st_next.power[i] = 1'b0;
            st_next.enabled[i] = 1'b0;
         end
         if (st_reg.resetting[i] && st_reg.rst_cnt == 18'h00000) begin
            st_next.resetting[i] = 1'b0;
            st_next.enabled[i] = 1'b1;
            st_next.change[i] = 1'b1;
         end
         // Route switches only between packets.
         if (PKT_BOUNDARY) begin
            // Path follows the attached device's speed, ready before the port is enabled
            st_next.route_tt[i] = conn[i] && st_reg.hs && !DN_HS_DEV[i];
            st_next.route_rpt[i] = conn[i] && !(st_reg.hs && !DN_HS_DEV[i]);
         end
      end
      if (|st_reg.resetting) begin
         st_next.rst_cnt = st_reg.rst_cnt - 18'h00001;
      end

      // Host port commands
      cp = PWDATA[5:4];
      cmd = PWDATA[2:0];
      hit = 4'h0;
      if (apb_wr && PADDR == uhpc_pkg::ADDR_PORT_CMD && st_reg.configured && usable[cp]) begin
         hit = st_reg.cfg[uhpc_pkg::CFG_GANGED] ? usable : (4'h1 << cp);
         case (cmd)
            uhpc_pkg::CMD_SET_POWER: st_next.power = st_next.power | hit;
            uhpc_pkg::CMD_CLR_POWER: begin
               st_next.power = st_next.power & ~hit;
               st_next.enabled = st_next.enabled & ~hit;
            end
            uhpc_pkg::CMD_SET_RESET: begin
               if (conn[cp] && st_reg.power[cp] && !(|st_reg.resetting)) begin
                  st_next.resetting[cp] = 1'b1;
                  st_next.rst_cnt = 18'(uhpc_pkg::PORT_RESET_CYCLES);
               end
            end
            uhpc_pkg::CMD_CLR_ENABLE: st_next.enabled[cp] = 1'b0;
            uhpc_pkg::CMD_SET_SUSPEND: st_next.suspended[cp] = st_reg.enabled[cp];
            uhpc_pkg::CMD_CLR_SUSPEND: st_next.suspended[cp] = 1'b0;
            default: st_next.power = st_next.power;
         endcase
      end
      if (apb_wr && PADDR == uhpc_pkg::ADDR_CTRL) begin
         st_next.configured = PWDATA[uhpc_pkg::CTRL_CONFIGURED] && st_reg.up == uhpc_pkg::UP_RUN;
         st_next.hub_susp = PWDATA[uhpc_pkg::CTRL_HUB_SUSP];
         st_next.led_ovr = PWDATA[uhpc_pkg::CTRL_LED_OVR_LSB +: 4];
      end
      // Config is only writable while loading, the load path owns it
      if (apb_wr && PADDR == uhpc_pkg::ADDR_CFG && st_reg.up == uhpc_pkg::UP_LOAD) begin
         st_next.cfg = PWDATA;
      end
      // Write-one-to-clear; a same-cycle event wins only on a bit that was not already set
      if (apb_wr && PADDR == uhpc_pkg::ADDR_CHANGE) begin
         st_next.change = st_next.change & ~(PWDATA[3:0] & ~(st_next.change & ~st_reg.change));
         st_next.oc_flag = st_next.oc_flag & ~(PWDATA[7:4] & ~(st_next.oc_flag & ~st_reg.oc_flag));
      end
      if (!st_next.configured) begin
         st_next.power = 4'h0;
         st_next.enabled = 4'h0;
         st_next.suspended = 4'h0;
         st_next.resetting = 4'h0;
      end

      if (apb_rd) begin
         case (PADDR)
            uhpc_pkg::ADDR_CTRL: st_next.prdata = {24'h0, st_reg.led_ovr, 1'b0, st_reg.hub_susp,
               st_reg.configured, st_reg.up != uhpc_pkg::UP_LOAD};
            uhpc_pkg::ADDR_CFG: st_next.prdata = st_reg.cfg;
            uhpc_pkg::ADDR_STATUS: st_next.prdata = {26'h0, st_reg.up, st_reg.hs};
            uhpc_pkg::ADDR_PORT_STAT: st_next.prdata = {12'h0, st_reg.resetting, st_reg.oc_flag,
               st_reg.suspended, st_reg.enabled, st_reg.power};
            uhpc_pkg::ADDR_CHANGE: st_next.prdata = {24'h0, st_reg.oc_flag, st_reg.change};
            default: st_next.prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         st_reg <= '0;
         st_reg.cfg <= uhpc_pkg::CFG_RESET;
         st_reg.up <= uhpc_pkg::UP_LOAD;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic unmapped;
   assign unmapped = PADDR > uhpc_pkg::ADDR_CHANGE || PADDR[1:0] != 2'h0;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && unmapped;
   assign PRDATA = st_reg.prdata;

   assign UP_PULLUP_EN = (st_reg.up != uhpc_pkg::UP_LOAD) && (st_reg.up != uhpc_pkg::UP_WAIT_VBUS)
      && !st_reg.hs;
   assign UP_CHIRP_TX = st_reg.up == uhpc_pkg::UP_CHIRP;
   assign UP_HIGH_SPEED = st_reg.hs;
   assign UP_WAKE_FWD = st_reg.wake_fwd;
   // Downstream babble and disconnects never reach upstream while connectivity runs; remote wakeup still goes out on UP_WAKE_FWD.
   assign UP_TX_BLOCK = st_reg.up == uhpc_pkg::UP_RUN;
   assign HUB_CHANGE_EP1 = |{st_reg.change, st_reg.oc_flag};
   assign DN_SE0_DRIVE = st_reg.configured ? 4'h0 : 4'hF;
   assign DN_PORT_RESET = st_reg.resetting;
   assign DN_ROUTE_TT = st_reg.route_tt;
   assign DN_ROUTE_RPT = st_reg.route_rpt;
   assign PORT_POWER_ENABLE_N = st_reg.power ^ {4{~st_reg.cfg[uhpc_pkg::CFG_PWR_POL]}};
   // Automatic mode never blinks; host override masks green only.
   assign LED_GREEN = st_reg.cfg[uhpc_pkg::CFG_LED_MAN] ? st_reg.led_ovr
      : (st_reg.enabled & ~st_reg.led_ovr);
   assign LED_AMBER = st_reg.cfg[uhpc_pkg::CFG_LED_MAN] ? 4'h0 : st_reg.oc_flag;
endmodule

// File: test/uhpc_assertions.sv
`timescale 1ns/100ps
module uhpc_assertions (
   input wire logic REF_CLK, // Device clock
   input wire logic NRST, // Synchronous reset, active low
   input wire logic UPSTREAM_BUS_POWER_SENSE, // Upstream bus power pin
   input wire logic UP_CHIRP_ANSWER, // Host chirp seen
   input wire logic UP_PULLUP_EN, // D+ pull-up enable
   input wire logic UP_CHIRP_TX, // Device chirp
   input wire logic UP_HIGH_SPEED, // High speed flag
   input wire logic UP_TX_BLOCK, // Upstream blocking
   input wire logic [3:0] DN_HS_DEV, // High speed devices
   input wire logic PKT_BOUNDARY, // Packet boundary
   input wire logic [3:0] DN_SE0_DRIVE, // Data lines driven low
   input wire logic [3:0] DN_ROUTE_TT, // Translator routing
   input wire logic [3:0] DN_ROUTE_RPT // Repeater routing
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!NRST);
   ////////////////////////////////////////////////////////////////////////////
   property p_hs_pullup;
      UP_HIGH_SPEED |-> !UP_PULLUP_EN;
   endproperty
   a_hs_pullup: assert property (p_hs_pullup) else $error("pull-up on at high speed");
   property p_chirp_hs;
      UP_CHIRP_TX && UP_CHIRP_ANSWER |-> ##[1:3] UP_HIGH_SPEED;
   endproperty
   a_chirp_hs: assert property (p_chirp_hs) else $error("answered chirp gave no high speed");
   property p_fs_keep;
      $fell(UP_CHIRP_TX) && !UP_HIGH_SPEED |-> UP_PULLUP_EN;
   endproperty
   a_fs_keep: assert property (p_fs_keep) else $error("full speed hub lost pull-up");
   property p_chirp_se0;
      UP_CHIRP_TX [*2] |-> DN_SE0_DRIVE == 4'hF;
   endproperty
   a_chirp_se0: assert property (p_chirp_se0) else $error("ports not driven low after bus reset");
   property p_tx_block;
      $fell(UP_CHIRP_TX) |-> UP_TX_BLOCK;
   endproperty
   a_tx_block: assert property (p_tx_block) else $error("upstream not blocked when running");
   property p_route_hs;
      PKT_BOUNDARY && UP_HIGH_SPEED |=> (DN_ROUTE_TT & $past(DN_HS_DEV)) == 4'h0;
   endproperty
   a_route_hs: assert property (p_route_hs) else $error("high speed device sent via translator");
   property p_route_stable;
      !PKT_BOUNDARY |=> $stable(DN_ROUTE_TT) && $stable(DN_ROUTE_RPT);
   endproperty
   a_route_stable: assert property (p_route_stable) else $error("routing changed off boundary");
   property p_vbus_attach;
      !UPSTREAM_BUS_POWER_SENSE [*4] |-> !$rose(UP_PULLUP_EN);
   endproperty
   a_vbus_attach: assert property (p_vbus_attach) else $error("attached without bus power");
endmodule

// File: test/uhpc_host_model.sv
`timescale 1ns/100ps
module uhpc_host_model (
   input wire logic clk, // Device clock
   input wire logic start, // Begin one bus reset
   input wire logic hs_host, // Host is high speed capable
   input wire logic chirp_tx, // Device chirp
   output logic bus_reset, // Bus reset level
   output logic chirp_answer // Host chirp sequence
);
   logic [5:0] cnt_reg = 6'h00;
   initial begin
      bus_reset = 1'b0;
      chirp_answer = 1'b0;
   end
   always @(posedge clk) begin
      if (start && cnt_reg == 6'h00) cnt_reg <= 6'h28;
      else if (cnt_reg != 6'h00) cnt_reg <= cnt_reg - 6'h01;
      bus_reset <= cnt_reg > 6'h01 || start;
      // Old hosts never answer, so the device must stay at full speed
      chirp_answer <= hs_host && chirp_tx && cnt_reg > 6'h01 && cnt_reg < 6'h1E;
   end
endmodule

// File: test/tb.sv
`timescale 1ns/100ps
module tb;
   logic REF_CLK, NRST, PSEL, PENABLE, PWRITE, CFG_LOAD_DONE, UPSTREAM_BUS_POWER_SENSE;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA, r;
   logic PREADY, PSLVERR, UP_BUS_RESET, UP_CHIRP_ANSWER, UP_PULLUP_EN, UP_CHIRP_TX, UP_HIGH_SPEED;
   logic UP_WAKE_FWD, UP_TX_BLOCK, EOF2_PAST, PKT_BOUNDARY, HUB_CHANGE_EP1, e, host_start, host_hs;
   logic [3:0] DN_CONNECT, DN_HS_DEV, DN_NONIDLE, DN_WAKE, DN_SE0_DRIVE, DN_PORT_RESET, DN_ROUTE_TT;
   logic [3:0] DN_ROUTE_RPT, PORT_POWER_ENABLE_N, PORT_OVERCURRENT_SENSE_N, LED_GREEN, LED_AMBER;
   int n_errors = 0;
   int n_compared = 0;
   uhpc_top u_uhpc_top (.REF_CLK, .NRST, .PADDR, .PSEL, .PENABLE, .PWRITE, .PWDATA, .PRDATA, .PREADY,
      .PSLVERR, .CFG_LOAD_DONE, .UPSTREAM_BUS_POWER_SENSE, .UP_BUS_RESET, .UP_CHIRP_ANSWER, .UP_PULLUP_EN,
      .UP_CHIRP_TX, .UP_HIGH_SPEED, .UP_WAKE_FWD, .UP_TX_BLOCK, .DN_CONNECT, .DN_HS_DEV, .DN_NONIDLE,
      .DN_WAKE, .EOF2_PAST, .PKT_BOUNDARY, .DN_SE0_DRIVE, .DN_PORT_RESET, .DN_ROUTE_TT, .DN_ROUTE_RPT,
      .PORT_POWER_ENABLE_N, .PORT_OVERCURRENT_SENSE_N, .LED_GREEN, .LED_AMBER, .HUB_CHANGE_EP1);
   uhpc_host_model u_uhpc_host_model (.clk(REF_CLK), .start(host_start), .hs_host(host_hs),
      .chirp_tx(UP_CHIRP_TX), .bus_reset(UP_BUS_RESET), .chirp_answer(UP_CHIRP_ANSWER));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      REF_CLK = 1'b0;
      forever #25 REF_CLK = ~REF_CLK;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge REF_CLK);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Each transfer starts one edge after the last release, so no signal is set twice per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      @(posedge REF_CLK);
      while (PREADY !== 1'b1 && n < 20) begin
         n++;
         @(posedge REF_CLK);
      end
      if (n == 20) n_errors++;
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic end_of_test;
      if (n_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic bus_reset(input logic hs);
      host_hs <= hs;
      host_start <= 1'b1;
      tick(1);
      host_start <= 1'b0;
      tick(60);
   endtask
   initial begin
      repeat (45000) @(posedge REF_CLK);
      n_errors++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {NRST, PSEL, PENABLE, PWRITE, CFG_LOAD_DONE, UPSTREAM_BUS_POWER_SENSE} = 6'h00;
      {PADDR, PWDATA, EOF2_PAST, PKT_BOUNDARY, host_start, host_hs} = 44'h0;
      {DN_HS_DEV, DN_NONIDLE, DN_WAKE} = 12'h000;
      DN_CONNECT = 4'hF;
      PORT_OVERCURRENT_SENSE_N = 4'hF;
      tick(2);
      NRST <= 1'b1;
      apb(1'b0, uhpc_pkg::ADDR_CFG, 32'h0); chk(r, 32'h0008_880F);
      chk(PORT_POWER_ENABLE_N, 4'hF);
      chk(DN_SE0_DRIVE, 4'hF);
      // Disabled-port window 1 ms, active-low pins, per-port power
      apb(1'b1, uhpc_pkg::ADDR_CFG, 32'h0001_000F);
      UPSTREAM_BUS_POWER_SENSE <= 1'b1;
      tick(6);
      chk(UP_PULLUP_EN, 1'b0);
      CFG_LOAD_DONE <= 1'b1;
      tick(6);
      chk(UP_PULLUP_EN, 1'b1);
      bus_reset(1'b1);
      chk(UP_HIGH_SPEED, 1'b1);
      chk(UP_PULLUP_EN, 1'b0);
      apb(1'b0, uhpc_pkg::ADDR_STATUS, 32'h0); chk(r, 32'h21);
      apb(1'b1, uhpc_pkg::ADDR_CTRL, 32'h2);
      apb(1'b0, uhpc_pkg::ADDR_CTRL, 32'h0); chk(r, 32'h3);
      chk(DN_SE0_DRIVE, 4'h0);
      apb(1'b1, uhpc_pkg::ADDR_PORT_CMD, {26'h0, 2'h1, 1'b0, uhpc_pkg::CMD_SET_POWER});
      tick(2);
      chk(PORT_POWER_ENABLE_N, 4'hD);
      apb(1'b1, uhpc_pkg::ADDR_PORT_CMD, {26'h0, 2'h1, 1'b0, uhpc_pkg::CMD_SET_RESET});
      tick(1);
      chk(DN_PORT_RESET, 4'h2);
      chk(LED_GREEN, 4'h0);
      DN_HS_DEV <= 4'h5;
      PKT_BOUNDARY <= 1'b1;
      tick(1);
      PKT_BOUNDARY <= 1'b0;
      tick(1);
      chk(DN_ROUTE_TT, 4'hA);
      chk(DN_ROUTE_RPT, 4'h5);
      DN_HS_DEV <= 4'h0;
      tick(3);
      chk(DN_ROUTE_TT, 4'hA);
      apb(1'b0, 8'h20, 32'h0); chk({e, r}, 33'h1_0000_0000);
      // One-cycle release must restart the filter window
      PORT_OVERCURRENT_SENSE_N <= 4'hD;
      tick(15000);
      PORT_OVERCURRENT_SENSE_N <= 4'hF;
      tick(1);
      PORT_OVERCURRENT_SENSE_N <= 4'hD;
      tick(15000);
      chk(PORT_POWER_ENABLE_N, 4'hD);
      tick(6000);
      chk(PORT_POWER_ENABLE_N, 4'hF);
      chk(LED_AMBER, 4'h2);
      chk(HUB_CHANGE_EP1, 1'b1);
      apb(1'b0, uhpc_pkg::ADDR_PORT_STAT, 32'h0); chk(r[15:12], 4'h2);
      PORT_OVERCURRENT_SENSE_N <= 4'hF;
      bus_reset(1'b0);
      chk(UP_HIGH_SPEED, 1'b0);
      chk(UP_PULLUP_EN, 1'b1);
      chk(DN_SE0_DRIVE, 4'hF);
      apb(1'b0, uhpc_pkg::ADDR_CTRL, 32'h0); chk(r[1], 1'b0);
      end_of_test();
   end
endmodule
bind uhpc_top uhpc_assertions u_uhpc_assertions (.REF_CLK, .NRST, .UPSTREAM_BUS_POWER_SENSE, .UP_CHIRP_ANSWER,
   .UP_PULLUP_EN, .UP_CHIRP_TX, .UP_HIGH_SPEED, .UP_TX_BLOCK, .DN_HS_DEV, .PKT_BOUNDARY, .DN_SE0_DRIVE,
   .DN_ROUTE_TT, .DN_ROUTE_RPT);
